// >>> inc/sps_consts.vh
// constants for the stack pointer and shadow register block
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// ----------------------------------------
// reset values and stack bounds
// ----------------------------------------
`define SPS_SP_RST 16'h0800
`define SPS_LIM_RST 16'h0000
`define SPS_STK_FLOOR 16'h0800
`define SPS_LIM_MARGIN 17'h0_0002
`define SPS_WORD_STEP 16'h0002
`define SPS_WORD_STEP17 17'h0_0002

// ----------------------------------------
// register offsets on the bus
// ----------------------------------------
`define SPS_OFS_SP 8'h00
`define SPS_OFS_LIM 8'h04
`define SPS_OFS_STAT 8'h08

// ----------------------------------------
// status register flag positions
// ----------------------------------------
`define SPS_BIT_C 0
`define SPS_BIT_Z 1
`define SPS_BIT_OVF 2
`define SPS_BIT_N 3
`define SPS_BIT_HC 8

// ----------------------------------------
// stack operation codes
// ----------------------------------------
`define SPS_OP_PUSH 3'h0
`define SPS_OP_POP 3'h1
`define SPS_OP_CALL 3'h2
`define SPS_OP_EXC 3'h3
`define SPS_OP_RET 3'h4

// ----------------------------------------
// bus encodings and the stack pointer register index
// ----------------------------------------
`define SPS_HSIZE_BYTE 3'h0
`define SPS_SP_INDEX 4'hf

`endif

// >>> rtl/sps_core_regs.v
// working registers, stack pointer, stack limit and shadow transfers
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_core_regs (
	// clock and reset
	input wire mclk,
	input wire reset,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// working register access
	input wire wrEn,
	input wire wrByte,
	input wire [3:0] wrIdx,
	input wire [15:0] wrData,
	input wire [3:0] rdIdx,
	output reg [15:0] rdData_r,
	// pointer use and stack-relative address
	input wire ptrUse,
	input wire [3:0] ptrIdx,
	input wire eaUse,
	input wire [15:0] eaOffset,
	// shadow transfers
	input wire shadowSave,
	input wire shadowRestore,
	input wire [15:0] statusIn,
	output reg [15:0] flagsOut_r,
	output reg flagsLoad_r,
	// stack operations
	input wire opStart,
	input wire [2:0] opCode,
	input wire [15:0] opData,
	input wire [22:0] opPc,
	input wire [3:0] opDst,
	input wire [15:0] memRdData,
	output reg busy_r,
	output reg [15:0] memAddr_r,
	output reg [15:0] memWrData_r,
	output reg memWr_r,
	output reg memRd_r,
	output reg [22:0] retPc_r,
	output reg retValid_r,
	output reg [15:0] stackPtr_r,
	// requests to exception logic
	output reg trapReq_r,
	output reg resetReq_r
);

	// ----------------------------------------
	// local codes
	// ----------------------------------------
	localparam S_IDLE = 2'd0;
	localparam S_PUSH2 = 2'd1;
	localparam S_RDWAIT = 2'd2;
	localparam S_RDTAKE = 2'd3;

	localparam K_POP = 2'd0;
	localparam K_RETHI = 2'd1;
	localparam K_RETLO = 2'd2;

	localparam SEL_NONE = 2'd0;
	localparam SEL_SP = 2'd1;
	localparam SEL_LIM = 2'd2;
	localparam SEL_STAT = 2'd3;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [15:0] wReg [0:14];
	reg [14:0] initFlag_r;
	reg [15:0] stackLim_r;
	reg chkEn_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [1:0] kind_r;
	reg [1:0] kind_nxt;
	reg [15:0] hiWord_r;
	reg [15:0] hiWord_nxt;
	reg [6:0] retHi_r;
	reg [6:0] retHi_nxt;
	reg [3:0] popDst_r;
	reg [3:0] popDst_nxt;
	reg [15:0] memAddr_nxt;
	reg [15:0] memWrData_nxt;
	reg memWr_nxt;
	reg memRd_nxt;
	reg [22:0] retPc_nxt;
	reg retValid_nxt;
	reg [15:0] spSeq;
	reg spSeqWe;
	reg popWe;
	reg accValid;
	reg [15:0] accAddr;
	reg accWrap;
	reg ahbWrPh_r;
	reg ahbRdPh_r;
	reg [7:0] ahbAddr_r;
	reg [2:0] ahbSize_r;
	reg [31:0] ahbRdVal;
	integer i;

	wire [16:0] spPlus2;
	wire [15:0] spMinus2;
	wire spLow;
	wire [16:0] eaSum;
	wire eaWrap;
	wire seqTrap;
	wire eaTrap;
	wire [63:0] shW;
	wire [4:0] shFlags;
	wire [4:0] flagsPack;
	wire ahbTake;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [1:0] regSel;
		input [7:0] ofs;
		begin
			case (ofs)
				`SPS_OFS_SP: regSel = SEL_SP;
				`SPS_OFS_LIM: regSel = SEL_LIM;
				`SPS_OFS_STAT: regSel = SEL_STAT;
				default: regSel = SEL_NONE;
			endcase
		end
	endfunction

	assign spPlus2 = {1'b0, stackPtr_r} + `SPS_WORD_STEP17;
	assign spMinus2 = stackPtr_r - `SPS_WORD_STEP;
	assign spLow = stackPtr_r < `SPS_WORD_STEP;
	// wrap shows as carry for forward offsets, missing carry for negative ones
	assign eaSum = {1'b0, stackPtr_r} + {1'b0, eaOffset};
	assign eaWrap = eaOffset[15] ? ~eaSum[16] : eaSum[16];
	assign flagsPack = {statusIn[`SPS_BIT_HC], statusIn[`SPS_BIT_N],
		statusIn[`SPS_BIT_OVF], statusIn[`SPS_BIT_Z], statusIn[`SPS_BIT_C]};
	assign ahbTake = hsel & htrans[1] & hready;

	// ----------------------------------------
	// shadows and address checks
	// ----------------------------------------
	sps_shadow #(
		.NREG(4)
	) uShadow (
		.mclk(mclk),
		.reset(reset),
		.save(shadowSave),
		.wIn({wReg[3], wReg[2], wReg[1], wReg[0]}),
		.flagsIn(flagsPack),
		.shW(shW),
		.shFlags_r(shFlags)
	);

	sps_stack_chk uSeqChk (
		.addr(accAddr),
		.wrap(accWrap),
		.limit(stackLim_r),
		.chkEn(chkEn_r),
		.trap(seqTrap)
	);

	sps_stack_chk uEaChk (
		.addr(eaSum[15:0]),
		.wrap(eaWrap),
		.limit(stackLim_r),
		.chkEn(chkEn_r),
		.trap(eaTrap)
	);

	// ----------------------------------------
	// stack sequencer
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		hiWord_nxt = hiWord_r;
		retHi_nxt = retHi_r;
		popDst_nxt = popDst_r;
		memAddr_nxt = memAddr_r;
		memWrData_nxt = memWrData_r;
		memWr_nxt = 1'b0;
		memRd_nxt = 1'b0;
		retPc_nxt = retPc_r;
		retValid_nxt = 1'b0;
		spSeq = stackPtr_r;
		spSeqWe = 1'b0;
		popWe = 1'b0;
		accValid = 1'b0;
		accAddr = stackPtr_r;
		accWrap = 1'b0;
		case (state_r)
			S_IDLE: begin
				if (opStart) begin
					if (opCode == `SPS_OP_POP || opCode == `SPS_OP_RET) begin
						// pre-decrement, then read
						accValid = 1'b1;
						accAddr = spMinus2;
						accWrap = spLow;
						memAddr_nxt = spMinus2;
						memRd_nxt = 1'b1;
						spSeq = spMinus2;
						spSeqWe = 1'b1;
						popDst_nxt = opDst;
						kind_nxt = (opCode == `SPS_OP_POP) ? K_POP : K_RETHI;
						state_nxt = S_RDWAIT;
					end else begin
						// write, then post-increment
						accValid = 1'b1;
						accWrap = spPlus2[16];
						memAddr_nxt = stackPtr_r;
						memWr_nxt = 1'b1;
						spSeq = spPlus2[15:0];
						spSeqWe = 1'b1;
						if (opCode == `SPS_OP_CALL) begin
							memWrData_nxt = opPc[15:0];
							hiWord_nxt = {8'h00, 1'b0, opPc[22:16]};
							state_nxt = S_PUSH2;
						end else if (opCode == `SPS_OP_EXC) begin
							memWrData_nxt = opPc[15:0];
							hiWord_nxt = {statusIn[7:0], 1'b0, opPc[22:16]};
							state_nxt = S_PUSH2;
						end else begin
							memWrData_nxt = opData;
						end
					end
				end
			end
			S_PUSH2: begin
				// second word of a program counter push
				accValid = 1'b1;
				accWrap = spPlus2[16];
				memAddr_nxt = stackPtr_r;
				memWrData_nxt = hiWord_r;
				memWr_nxt = 1'b1;
				spSeq = spPlus2[15:0];
				spSeqWe = 1'b1;
				state_nxt = S_IDLE;
			end
			S_RDWAIT: begin
				state_nxt = S_RDTAKE;
			end
			S_RDTAKE: begin
				if (kind_r == K_POP) begin
					popWe = 1'b1;
					state_nxt = S_IDLE;
				end else if (kind_r == K_RETHI) begin
					// high part first on the way back
					retHi_nxt = memRdData[6:0];
					accValid = 1'b1;
					accAddr = spMinus2;
					accWrap = spLow;
					memAddr_nxt = spMinus2;
					memRd_nxt = 1'b1;
					spSeq = spMinus2;
					spSeqWe = 1'b1;
					kind_nxt = K_RETLO;
					state_nxt = S_RDWAIT;
				end else begin
					retPc_nxt = {retHi_r, memRdData};
					retValid_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			kind_r <= K_POP;
			hiWord_r <= 16'h0000;
			retHi_r <= 7'h00;
			popDst_r <= 4'h0;
			memAddr_r <= 16'h0000;
			memWrData_r <= 16'h0000;
			memWr_r <= 1'b0;
			memRd_r <= 1'b0;
			retPc_r <= 23'h00_0000;
			retValid_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			hiWord_r <= hiWord_nxt;
			retHi_r <= retHi_nxt;
			popDst_r <= popDst_nxt;
			memAddr_r <= memAddr_nxt;
			memWrData_r <= memWrData_nxt;
			memWr_r <= memWr_nxt;
			memRd_r <= memRd_nxt;
			retPc_r <= retPc_nxt;
			retValid_r <= retValid_nxt;
			busy_r <= state_nxt != S_IDLE;
		end
	end

	// ----------------------------------------
	// trap and reset requests
	// ----------------------------------------
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			trapReq_r <= 1'b0;
			resetReq_r <= 1'b0;
		end else begin
			trapReq_r <= (accValid & seqTrap) | (eaUse & eaTrap);
			resetReq_r <= ptrUse & (ptrIdx != `SPS_SP_INDEX)
				& ~initFlag_r[ptrIdx];
		end
	end

	// ----------------------------------------
	// working registers 0 to 14
	// ----------------------------------------
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			for (i = 0; i < 15; i = i + 1) begin
				wReg[i] <= 16'h0000;
			end
			initFlag_r <= 15'h0000;
		end else begin
			for (i = 0; i < 15; i = i + 1) begin
				if (shadowRestore && i < 4) begin
					wReg[i] <= shW[i*16 +: 16];
					initFlag_r[i] <= 1'b1;
				end else if (popWe && popDst_r == i[3:0]) begin
					wReg[i] <= memRdData;
					initFlag_r[i] <= 1'b1;
				end else if (wrEn && wrIdx == i[3:0]) begin
					if (wrByte) begin
						wReg[i] <= {wReg[i][15:8], wrData[7:0]};
					end else begin
						wReg[i] <= wrData;
						initFlag_r[i] <= 1'b1;
					end
				end
			end
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdData_r <= 16'h0000;
		end else if (rdIdx == `SPS_SP_INDEX) begin
			rdData_r <= stackPtr_r;
		end else begin
			rdData_r <= wReg[rdIdx];
		end
	end

	// ----------------------------------------
	// flag restore towards the status register
	// ----------------------------------------
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			flagsOut_r <= 16'h0000;
			flagsLoad_r <= 1'b0;
		end else begin
			flagsLoad_r <= shadowRestore;
			if (shadowRestore) begin
				flagsOut_r <= 16'h0000;
				flagsOut_r[`SPS_BIT_HC] <= shFlags[4];
				flagsOut_r[`SPS_BIT_N] <= shFlags[3];
				flagsOut_r[`SPS_BIT_OVF] <= shFlags[2];
				flagsOut_r[`SPS_BIT_Z] <= shFlags[1];
				flagsOut_r[`SPS_BIT_C] <= shFlags[0];
			end
		end
	end

	// ----------------------------------------
	// stack pointer and limit
	// ----------------------------------------
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			stackPtr_r <= `SPS_SP_RST;
		end else if (spSeqWe) begin
			stackPtr_r <= {spSeq[15:1], 1'b0};
		end else if (popWe && popDst_r == `SPS_SP_INDEX) begin
			stackPtr_r <= {memRdData[15:1], 1'b0};
		end else if (wrEn && wrIdx == `SPS_SP_INDEX) begin
			if (wrByte) begin
				stackPtr_r <= {stackPtr_r[15:8], wrData[7:1], 1'b0};
			end else begin
				stackPtr_r <= {wrData[15:1], 1'b0};
			end
		end else if (ahbWrPh_r && hready && regSel(ahbAddr_r) == SEL_SP) begin
			stackPtr_r <= {hwdata[15:1], 1'b0};
		end
	end

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			stackLim_r <= `SPS_LIM_RST;
			chkEn_r <= 1'b0;
		end else if (ahbWrPh_r && hready && regSel(ahbAddr_r) == SEL_LIM) begin
			if (ahbSize_r == `SPS_HSIZE_BYTE) begin
				stackLim_r <= {stackLim_r[15:8], hwdata[7:1], 1'b0};
			end else begin
				stackLim_r <= {hwdata[15:1], 1'b0};
				chkEn_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	always @* begin
		case (regSel(ahbAddr_r))
			SEL_SP: ahbRdVal = {16'h0000, stackPtr_r};
			SEL_LIM: ahbRdVal = {16'h0000, stackLim_r};
			SEL_STAT: ahbRdVal = {16'h0000, chkEn_r, initFlag_r};
			// shadows have no bus address at all
			default: ahbRdVal = 32'h0000_0000;
		endcase
	end

	// reads take one wait state so a preceding write is visible
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			ahbWrPh_r <= 1'b0;
			ahbRdPh_r <= 1'b0;
			ahbAddr_r <= 8'h00;
			ahbSize_r <= `SPS_HSIZE_BYTE;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (ahbRdPh_r) begin
				hrdata <= ahbRdVal;
				hreadyout <= 1'b1;
				ahbRdPh_r <= 1'b0;
			end else if (hready) begin
				ahbWrPh_r <= ahbTake & hwrite;
				ahbRdPh_r <= ahbTake & ~hwrite;
				hreadyout <= ~(ahbTake & ~hwrite);
				if (ahbTake) begin
					// nonzero upper address bits select nothing
					ahbAddr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
					ahbSize_r <= hsize;
				end
			end
		end
	end

endmodule // sps_core_regs

// >>> rtl/sps_shadow.v
// one-level shadow copies of the low working registers and flags
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_shadow #(
	parameter NREG = 4
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	// capture
	input wire save,
	input wire [NREG*16-1:0] wIn,
	input wire [4:0] flagsIn,
	// held copies
	output wire [NREG*16-1:0] shW,
	output reg [4:0] shFlags_r
);

	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : gShadow
			reg [15:0] sh_r;
			// a new save simply overwrites, no stacking
			always @(posedge mclk or posedge reset) begin
				if (reset) begin
					sh_r <= 16'h0000;
				end else if (save) begin
					sh_r <= wIn[g*16 +: 16];
				end
			end
			assign shW[g*16 +: 16] = sh_r;
		end
	endgenerate

	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			shFlags_r <= 5'h00;
		end else if (save) begin
			shFlags_r <= flagsIn;
		end
	end

endmodule // sps_shadow

// >>> rtl/sps_stack_chk.v
// stack address checker: limit, wrap and floor
`timescale 1ns/1ps
`include "sps_consts.vh"

module sps_stack_chk (
	// address under test
	input wire [15:0] addr,
	input wire wrap,
	// limit state
	input wire [15:0] limit,
	input wire chkEn,
	// result
	output wire trap
);

	wire overLim;
	wire underFloor;

	// pointer two above the limit is still allowed
	assign overLim = {1'b0, addr} > ({1'b0, limit} + `SPS_LIM_MARGIN);
	assign underFloor = addr < `SPS_STK_FLOOR;
	assign trap = (chkEn & (wrap | overLim)) | underFloor;

endmodule // sps_stack_chk

// >>> testbench/sps_core_regs_assertions.sv
// assertions on the stack pointer and shadow register block
`timescale 1ns/1ps
`include "sps_consts.vh"
module sps_chk (
	// clock and reset
	input wire mclk,
	input wire reset,
	// observed ports
	input wire opStart,
	input wire [2:0] opCode,
	input wire [15:0] statusIn,
	input wire busy_r,
	input wire [15:0] memAddr_r,
	input wire [15:0] memWrData_r,
	input wire memWr_r,
	input wire memRd_r,
	input wire retValid_r,
	input wire [15:0] stackPtr_r,
	input wire ptrUse,
	input wire shadowRestore,
	input wire flagsLoad_r,
	input wire resetReq_r
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	wire go = opStart && !busy_r;
	wire [7:0] stLow = statusIn[7:0];
	a_sp_align: assert property (!stackPtr_r[0]) else $error("odd stack pointer");
	a_sp_reset: assert property ($fell(reset) |-> stackPtr_r == `SPS_SP_RST)
		else $error("bad stack pointer after reset");
	a_push_step: assert property (go && opCode == `SPS_OP_PUSH |=> memWr_r &&
		memAddr_r == $past(stackPtr_r) && stackPtr_r == memAddr_r + 16'h0002) else $error("bad push");
	a_pop_step: assert property (go && opCode == `SPS_OP_POP |=> memRd_r &&
		memAddr_r == $past(stackPtr_r) - 16'h0002 && stackPtr_r == memAddr_r) else $error("bad pop");
	a_call_order: assert property (go && opCode == `SPS_OP_CALL |=> memWr_r &&
		memAddr_r == $past(stackPtr_r) ##1 memWr_r && memWrData_r[15:8] == 8'h00
		&& memAddr_r == $past(memAddr_r) + 16'h0002) else $error("bad call push");
	a_exc_status: assert property (go && opCode == `SPS_OP_EXC |=> ##1 memWr_r &&
		memWrData_r[15:8] == $past(stLow, 2)) else $error("status byte not stacked");
	a_ret_done: assert property (go && opCode == `SPS_OP_RET |-> ##5 retValid_r &&
		stackPtr_r == $past(stackPtr_r, 5) - 16'h0004) else $error("bad return");
	a_uninit_req: assert property (resetReq_r |-> $past(ptrUse)) else $error("stray reset");
	a_restore_load: assert property (shadowRestore |=> flagsLoad_r) else $error("no flag load");
endmodule // sps_chk

bind sps_core_regs sps_chk chk (.mclk, .reset, .opStart, .opCode, .statusIn, .busy_r, .memAddr_r,
	.memWrData_r, .memWr_r, .memRd_r, .retValid_r, .stackPtr_r, .ptrUse, .shadowRestore,
	.flagsLoad_r, .resetReq_r);

// >>> testbench/sps_stack_mem.sv
// stack memory partner answering the block's stack strobes
`timescale 1ns/1ps
module sps_stack_mem (
	// clock
	input wire mclk,
	// strobes from the block
	input wire [15:0] memAddr_r,
	input wire [15:0] memWrData_r,
	input wire memWr_r,
	input wire memRd_r,
	// read data back
	output logic [15:0] memRdData
);
	logic [15:0] mem [0:127];
	initial memRdData = 16'h0000;
	always @(posedge mclk) begin
		if (memWr_r) mem[memAddr_r[7:1]] <= memWrData_r;
		// valid one cycle after the strobe, churning otherwise
		memRdData <= memRd_r ? mem[memAddr_r[7:1]] : ~memRdData;
	end
endmodule // sps_stack_mem

// >>> testbench/stack_pointer_and_shadow_regs_bench.sv
// testbench for the stack pointer and shadow register block
`timescale 1ns/1ps
`include "sps_consts.vh"
module stack_pointer_and_shadow_regs_bench;
	logic mclk = 1'b0, reset = 1'b1, hsel = 1'b1, hwrite = 1'b0, wrEn = 1'b0, wrByte = 1'b0;
	logic ptrUse = 1'b0, eaUse = 1'b0, shadowSave = 1'b0, shadowRestore = 1'b0, opStart = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, opCode = 3'h0;
	logic [3:0] wrIdx = '0, rdIdx = '0, ptrIdx = '0, opDst = 4'h3;
	logic [15:0] wrData = '0, eaOffset = '0, statusIn = '0, opData = '0;
	logic [22:0] opPc = '0, rp;
	logic tr;
	wire [31:0] hrdata;
	wire hreadyout, hresp, flagsLoad_r, busy_r, memWr_r, memRd_r, retValid_r, trapReq_r, resetReq_r;
	wire [15:0] rdData_r, flagsOut_r, memAddr_r, memWrData_r, stackPtr_r, memRdData;
	wire [22:0] retPc_r;
	int mismatches = 0, checks_done = 0, cycles = 0;

	always #50 mclk = ~mclk;

	sps_core_regs dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .wrEn, .wrByte, .wrIdx, .wrData, .rdIdx, .rdData_r,
		.ptrUse, .ptrIdx, .eaUse, .eaOffset, .shadowSave, .shadowRestore, .statusIn, .flagsOut_r,
		.flagsLoad_r, .opStart, .opCode, .opData, .opPc, .opDst, .memRdData, .busy_r, .memAddr_r,
		.memWrData_r, .memWr_r, .memRd_r, .retPc_r, .retValid_r, .stackPtr_r, .trapReq_r,
		.resetReq_r);
	sps_stack_mem stk (.mclk, .memAddr_r, .memWrData_r, .memWr_r, .memRd_r, .memRdData);

	task close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			close_out;
		end
	end

	task chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// ------------------------------------------------
	// access tasks
	// ------------------------------------------------
	task ahb(input logic w, input logic [31:0] a, d);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task rdChk(input logic [31:0] a, e);
		ahb(1'b0, a, '0);
		chk("bus read", rd, e);
	endtask

	task wreg(input logic [3:0] i, input logic [15:0] d, input logic b);
		wrEn <= 1'b1;
		wrIdx <= i;
		wrData <= d;
		wrByte <= b;
		@(posedge mclk);
		wrEn <= 1'b0;
		@(posedge mclk);
	endtask

	task regChk(input logic [3:0] i, input logic [15:0] e);
		rdIdx <= i;
		repeat (2) @(posedge mclk);
		chk("register", {16'h0000, rdData_r}, {16'h0000, e});
	endtask

	task opChk(input logic [2:0] c, input logic [15:0] d, input logic [22:0] pc, input logic t);
		opCode <= c;
		opData <= d;
		opPc <= pc;
		opStart <= 1'b1;
		@(posedge mclk);
		opStart <= 1'b0;
		tr = 1'b0;
		repeat (7) begin
			#1;
			tr = tr | trapReq_r;
			if (retValid_r === 1'b1) rp = retPc_r;
			@(posedge mclk);
		end
		chk("trap", {31'h0000_0000, tr}, {31'h0000_0000, t});
	endtask

	task probe(input logic p, input logic [15:0] v, input logic e);
		ptrUse <= p;
		eaUse <= !p;
		ptrIdx <= v[3:0];
		eaOffset <= v;
		@(posedge mclk);
		ptrUse <= 1'b0;
		eaUse <= 1'b0;
		#1;
		chk("request", {31'h0000_0000, p ? resetReq_r : trapReq_r}, {31'h0000_0000, e});
		@(posedge mclk);
	endtask

	task shadow(input logic s);
		shadowSave <= s;
		shadowRestore <= !s;
		@(posedge mclk);
		shadowSave <= 1'b0;
		shadowRestore <= 1'b0;
		#1;
		if (!s) chk("flags", {16'h0000, flagsOut_r}, 32'h0000_0109);
		@(posedge mclk);
	endtask

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rdChk(32'h0000_0000, 32'h0000_0800);
		rdChk(32'h0000_0004, 32'h0000_0000);
		rdChk(32'h0000_0008, 32'h0000_0000);
		rdChk(32'h0000_000C, 32'h0000_0000);
		probe(1'b1, 16'h0005, 1'b1);
		wreg(4'h3, 16'h00AA, 1'b1);
		probe(1'b1, 16'h0003, 1'b1);
		wreg(4'h3, 16'h1234, 1'b0);
		probe(1'b1, 16'h0003, 1'b0);
		$display("test reset_init done");
		ahb(1'b1, 32'h0000_0000, 32'h0000_0901);
		rdChk(32'h0000_0000, 32'h0000_0900);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0800);
		opChk(`SPS_OP_PUSH, 16'h5A5A, '0, 1'b0);
		chk("sp", {16'h0000, stackPtr_r}, 32'h0000_0802);
		opChk(`SPS_OP_PUSH, 16'h3636, '0, 1'b0);
		opChk(`SPS_OP_POP, '0, '0, 1'b0);
		regChk(4'h3, 16'h3636);
		wreg(4'hF, 16'h0A01, 1'b0);
		regChk(4'hF, 16'h0A00);
		opChk(`SPS_OP_CALL, '0, 23'h5B_1234, 1'b0);
		chk("sp", {16'h0000, stackPtr_r}, 32'h0000_0A04);
		chk("low word", {16'h0000, stk.mem[0]}, 32'h0000_1234);
		chk("high word", {16'h0000, stk.mem[1]}, 32'h0000_005B);
		opChk(`SPS_OP_RET, '0, '0, 1'b0);
		chk("ret pc", {9'h000, rp}, 32'h005B_1234);
		statusIn <= 16'h01A5;
		opChk(`SPS_OP_EXC, '0, 23'h12_ABCD, 1'b0);
		chk("high word", {16'h0000, stk.mem[1]}, 32'h0000_A512);
		opChk(`SPS_OP_RET, '0, '0, 1'b0);
		chk("ret pc", {9'h000, rp}, 32'h0012_ABCD);
		$display("test stack_moves done");
		// one shadow user at a time
		for (int i = 0; i < 4; i++) wreg(i[3:0], 16'h1000 + i[15:0], 1'b0);
		statusIn <= 16'hFFFF;
		shadow(1'b1);
		for (int i = 0; i < 4; i++) wreg(i[3:0], 16'h2000 + i[15:0], 1'b0);
		statusIn <= 16'h01F9;
		shadow(1'b1);
		for (int i = 0; i < 4; i++) wreg(i[3:0], 16'h3000 + i[15:0], 1'b0);
		shadow(1'b0);
		for (int i = 0; i < 4; i++) regChk(i[3:0], 16'h2000 + i[15:0]);
		$display("test shadow done");
		ahb(1'b1, 32'h0000_0000, 32'h0000_07FE);
		opChk(`SPS_OP_PUSH, '0, '0, 1'b1);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0F00);
		opChk(`SPS_OP_PUSH, '0, '0, 1'b0);
		ahb(1'b1, 32'h0000_0004, 32'h0000_0901);
		rdChk(32'h0000_0004, 32'h0000_0900);
		rdChk(32'h0000_0008, 32'h0000_800F);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0902);
		opChk(`SPS_OP_PUSH, '0, '0, 1'b0);
		opChk(`SPS_OP_PUSH, '0, '0, 1'b1);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0902);
		opChk(`SPS_OP_CALL, '0, '0, 1'b1);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0902);
		probe(1'b0, 16'h0000, 1'b0);
		probe(1'b0, 16'h0004, 1'b1);
		ahb(1'b1, 32'h0000_0004, 32'h0000_FFFE);
		ahb(1'b1, 32'h0000_0000, 32'h0000_FFFE);
		opChk(`SPS_OP_PUSH, '0, '0, 1'b1);
		$display("test limits done");
		close_out;
	end
endmodule // stack_pointer_and_shadow_regs_bench
